//--- csp_pkg.sv
package csp_pkg;

    localparam int CLK_HZ = 250_000_000;
    localparam int ERR_TIME_MS = 1000;
    localparam int ERR_CYCLES = (CLK_HZ / 1000) * ERR_TIME_MS;
    localparam int LED_TIME_MS = 100;
    localparam int LED_CYCLES = (CLK_HZ / 1000) * LED_TIME_MS;
    localparam int ROM_WORDS = 256;
    localparam int MEM_DEPTH = 100;
    localparam int VAL_W = 16;

    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_SETTINGS = 32'h0000_0008;
    localparam logic [31:0] ADDR_MEM_IDX = 32'h0000_000c;
    localparam logic [31:0] ADDR_MEM_SRC_LIM = 32'h0000_0010;
    localparam logic [31:0] ADDR_MEM_DWELL = 32'h0000_0014;

    localparam int ST_SELFTEST_BIT = 0;
    localparam int ST_ERR_LSB = 1;
    localparam int ST_REMOTE_BIT = 4;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_RAM_FAIL_BIT = 6;
    localparam int ST_ROM_FAIL_BIT = 7;

    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_EXEC = 8'h58;
    localparam logic [7:0] CH_DIGIT0 = 8'h30;
    localparam logic [7:0] CH_DIGIT9 = 8'h39;

    localparam logic [VAL_W-1:0] OUT_EN_MAX = 16'h0001;
    localparam logic [VAL_W-1:0] DISP_MAX = 16'h0003;
    localparam logic [VAL_W-1:0] PROG_MAX = 16'h0002;
    localparam logic [VAL_W-1:0] TRIG_MAX = 16'h0005;
    localparam logic [VAL_W-1:0] LOC_MIN = 16'h0001;
    localparam logic [VAL_W-1:0] LOC_MAX = 16'h0064;
    localparam logic [VAL_W-1:0] STATUS_REQ_MAX = 16'h0001;
    localparam logic [6:0] LOC_RESET = 7'h01;
    localparam logic [47:0] RAM_PATTERN = 48'ha5c3_3c5a_f00f;

    typedef enum logic [1:0] {ERR_NONE, ILLEGAL_COMMAND_ERROR, ILLEGAL_OPTION_ERROR,
                              NO_REMOTE_ERROR} csp_err_e;
    typedef enum logic [1:0] {ST_RAM, ST_IDLE, ST_ROM, ST_LED} csp_test_e;
    typedef enum logic [3:0] {CMD_NONE, CMD_OUT_EN, CMD_DISP, CMD_PROG, CMD_TRIG, CMD_LOC,
                              CMD_SRC, CMD_LIM, CMD_DWELL, SELF_TEST_COMMAND,
                              STATUS_WORD_REQUEST} csp_cmd_e;

    typedef struct packed {
        logic out_en;
        logic [1:0] disp;
        logic [1:0] prog;
        logic [2:0] trig;
        logic [6:0] loc;
    } csp_set_s;

    typedef struct packed {
        logic [VAL_W-1:0] src;
        logic [VAL_W-1:0] lim;
        logic [VAL_W-1:0] dwell;
    } csp_mem_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } csp_rx_s;

    function automatic logic [7:0] rom_word(input logic [8:0] i);
        return i[7:0] ^ 8'h5a;
    endfunction

    function automatic logic [7:0] rom_sum();
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < ROM_WORDS; i++) begin
            acc = acc + rom_word(9'(i));
        end
        return acc;
    endfunction

endpackage

//--- csp_parser.sv
// How it works
// - self-test runs ROM check, LED check, sets flag
// - LED check lights every indicator briefly
// - self-test leaves settings and memory untouched
// - working memory tested only at power-up
// - self-test flag is one until first status read
// - status read clears the self-test flag
// - any invalid command discards whole string
// - rejected string sets status error bits
// - service request only when enabled for condition
// - error shown about one second, then normal
// - many commands per string, spaces skipped
// - letter without number means zero
// - unknown letter raises illegal command error
// - out-of-range number raises illegal option error
// - string outside remote mode raises no-remote error
// - hundred-entry program memory loaded over the link
// - commands held until execute character arrives
// - remote enable enters remote, go-to-local leaves
`timescale 1ns/10ps
module csp_parser #(
    parameter int ERR_CYCLES = csp_pkg::ERR_CYCLES,
    parameter int LED_CYCLES = csp_pkg::LED_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire csp_pkg::csp_rx_s rx,
    output logic rx_ready,
    input wire logic ren,
    input wire logic gtl,
    output logic remote,
    output logic srq,
    output logic leds_on,
    output csp_pkg::csp_err_e disp_err,
    output csp_pkg::csp_set_s settings
);
    typedef struct packed {
        logic hready_o;
        logic [31:0] rdata;
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [2:0] srq_mask;
        logic [6:0] mem_idx;
        logic ren_d;
        logic remote;
        logic srq;
        logic selftest_flag;
        logic [2:0] err_bits;
        logic ram_fail;
        logic rom_fail;
        csp_pkg::csp_err_e disp_err;
        logic [31:0] disp_cnt;
        csp_pkg::csp_test_e test;
        logic [8:0] idx;
        logic [7:0] rom_acc;
        logic [31:0] led_cnt;
        logic leds_on;
        logic rx_ready;
        logic open;
        csp_pkg::csp_cmd_e cmd;
        logic [csp_pkg::VAL_W-1:0] acc;
        logic ovf;
        csp_pkg::csp_err_e perr;
        csp_pkg::csp_set_s tmp;
        csp_pkg::csp_mem_s tmp_ent;
        logic mem_dirty;
        logic st_req;
        csp_pkg::csp_set_s live;
        csp_pkg::csp_mem_s [csp_pkg::MEM_DEPTH-1:0] mem;
    } csp_state_s;
    csp_state_s s_reg;
    csp_state_s s_next;
    function automatic csp_pkg::csp_cmd_e decode(input logic [7:0] b);
        case (b)
            8'h46: return csp_pkg::CMD_OUT_EN;
            8'h44: return csp_pkg::CMD_DISP;
            8'h50: return csp_pkg::CMD_PROG;
            8'h54: return csp_pkg::CMD_TRIG;
            8'h42: return csp_pkg::CMD_LOC;
            8'h49: return csp_pkg::CMD_SRC;
            8'h56: return csp_pkg::CMD_LIM;
            8'h57: return csp_pkg::CMD_DWELL;
            8'h4a: return csp_pkg::SELF_TEST_COMMAND;
            8'h55: return csp_pkg::STATUS_WORD_REQUEST;
            default: return csp_pkg::CMD_NONE;
        endcase
    endfunction
    // closes the pending command; its number defaults to zero when none was sent
    function automatic csp_state_s finish_cmd(input csp_state_s st);
        csp_state_s r;
        logic ok;
        logic [csp_pkg::VAL_W-1:0] v;
        r = st;
        v = st.acc;
        case (st.cmd)
            csp_pkg::CMD_OUT_EN: ok = v <= csp_pkg::OUT_EN_MAX;
            csp_pkg::CMD_DISP: ok = v <= csp_pkg::DISP_MAX;
            csp_pkg::CMD_PROG: ok = v <= csp_pkg::PROG_MAX;
            csp_pkg::CMD_TRIG: ok = v <= csp_pkg::TRIG_MAX;
            csp_pkg::CMD_LOC: ok = v >= csp_pkg::LOC_MIN && v <= csp_pkg::LOC_MAX;
            csp_pkg::SELF_TEST_COMMAND: ok = v == '0;
            csp_pkg::STATUS_WORD_REQUEST: ok = v <= csp_pkg::STATUS_REQ_MAX;
            default: ok = 1'b1;
        endcase
        ok = ok && !st.ovf;
        if (st.cmd != csp_pkg::CMD_NONE && !ok && r.perr == csp_pkg::ERR_NONE) begin
            r.perr = csp_pkg::ILLEGAL_OPTION_ERROR;
        end
        if (ok) begin
            case (st.cmd)
                csp_pkg::CMD_OUT_EN: r.tmp.out_en = v[0];
                csp_pkg::CMD_DISP: r.tmp.disp = v[1:0];
                csp_pkg::CMD_PROG: r.tmp.prog = v[1:0];
                csp_pkg::CMD_TRIG: r.tmp.trig = v[2:0];
                csp_pkg::CMD_LOC: begin
                    r.tmp.loc = v[6:0];
                    r.tmp_ent = st.mem[7'(v[6:0] - 7'h01)];
                end
                csp_pkg::CMD_SRC: r.tmp_ent.src = v;
                csp_pkg::CMD_LIM: r.tmp_ent.lim = v;
                csp_pkg::CMD_DWELL: r.tmp_ent.dwell = v;
                csp_pkg::SELF_TEST_COMMAND: r.st_req = 1'b1;
                default: r.st_req = r.st_req;
            endcase
            r.mem_dirty = r.mem_dirty || st.cmd inside {csp_pkg::CMD_SRC, csp_pkg::CMD_LIM,
                csp_pkg::CMD_DWELL};
        end
        r.cmd = csp_pkg::CMD_NONE;
        r.acc = '0;
        r.ovf = 1'b0;
        return r;
    endfunction
    logic addr_ok;
    logic rd_status;
    logic [19:0] acc_wide;
    logic [7:0] b;
    always_comb begin
        s_next = s_reg;
        b = rx.data;
        acc_wide = 20'(s_reg.acc) * 20'd10 + 20'(b - csp_pkg::CH_DIGIT0);
        addr_ok = hsel && htrans[1] && hready;
        rd_status = addr_ok && !hwrite && haddr == csp_pkg::ADDR_STATUS;
        // bus reads answer with zero wait; data registered into the data phase
        s_next.wr_pend = addr_ok && hwrite;
        s_next.wr_addr = haddr;
        if (addr_ok && !hwrite) begin
            case (haddr)
                csp_pkg::ADDR_CTRL: s_next.rdata = 32'(s_reg.srq_mask);
                csp_pkg::ADDR_STATUS: s_next.rdata = 32'({s_reg.rom_fail, s_reg.ram_fail,
                    s_reg.test != csp_pkg::ST_IDLE, s_reg.remote, s_reg.err_bits,
                    s_reg.selftest_flag});
                csp_pkg::ADDR_SETTINGS: s_next.rdata = 32'(s_reg.live);
                csp_pkg::ADDR_MEM_IDX: s_next.rdata = 32'(s_reg.mem_idx);
                csp_pkg::ADDR_MEM_SRC_LIM: s_next.rdata = (s_reg.mem_idx < 7'(csp_pkg::MEM_DEPTH))
                    ? {s_reg.mem[s_reg.mem_idx].lim, s_reg.mem[s_reg.mem_idx].src} : 32'h0000_0000;
                csp_pkg::ADDR_MEM_DWELL: s_next.rdata = (s_reg.mem_idx < 7'(csp_pkg::MEM_DEPTH))
                    ? 32'(s_reg.mem[s_reg.mem_idx].dwell) : 32'h0000_0000;
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end
        if (s_reg.wr_pend) begin
            case (s_reg.wr_addr)
                csp_pkg::ADDR_CTRL: s_next.srq_mask = hwdata[2:0];
                csp_pkg::ADDR_MEM_IDX: s_next.mem_idx = hwdata[6:0];
                default: s_next.srq_mask = s_reg.srq_mask;
            endcase
        end
        // clears come first so that a same-cycle event below wins
        if (rd_status) begin
            s_next.selftest_flag = 1'b0;
            s_next.err_bits = 3'h0;
            s_next.srq = 1'b0;
        end
        s_next.ren_d = ren;
        if (!ren || gtl) begin
            s_next.remote = 1'b0;
        end else if (!s_reg.ren_d) begin
            s_next.remote = 1'b1;
        end
        if (s_reg.disp_cnt != 32'h0) begin
            s_next.disp_cnt = s_reg.disp_cnt - 32'h1;
            if (s_reg.disp_cnt == 32'h1) begin
                s_next.disp_err = csp_pkg::ERR_NONE;
            end
        end
        case (s_reg.test)
            csp_pkg::ST_RAM: begin
                // power-up only: write a pattern, read it back, leave the word clear
                if (!s_reg.idx[0]) begin
                    s_next.mem[s_reg.idx[7:1]] = csp_pkg::RAM_PATTERN;
                end else begin
                    s_next.ram_fail = s_reg.ram_fail
                        || (s_reg.mem[s_reg.idx[7:1]] != csp_pkg::RAM_PATTERN);
                    s_next.mem[s_reg.idx[7:1]] = '0;
                end
                s_next.idx = s_reg.idx + 9'h1;
                if (s_reg.idx == 9'(2 * csp_pkg::MEM_DEPTH - 1)) begin
                    s_next.idx = 9'h0;
                    s_next.rom_acc = 8'h00;
                    s_next.test = csp_pkg::ST_ROM;
                end
            end
            csp_pkg::ST_ROM: begin
                s_next.rom_acc = s_reg.rom_acc + csp_pkg::rom_word(s_reg.idx);
                s_next.idx = s_reg.idx + 9'h1;
                if (s_reg.idx == 9'(csp_pkg::ROM_WORDS - 1)) begin
                    s_next.rom_fail = (s_next.rom_acc != csp_pkg::rom_sum());
                    s_next.idx = 9'h0;
                    s_next.led_cnt = 32'(LED_CYCLES);
                    s_next.leds_on = 1'b1;
                    s_next.test = csp_pkg::ST_LED;
                end
            end
            csp_pkg::ST_LED: begin
                s_next.led_cnt = s_reg.led_cnt - 32'h1;
                if (s_reg.led_cnt == 32'h1) begin
                    s_next.leds_on = 1'b0;
                    s_next.selftest_flag = 1'b1;
                    s_next.test = csp_pkg::ST_IDLE;
                end
            end
            default: s_next.test = csp_pkg::ST_IDLE;
        endcase
        if (rx.valid && s_reg.rx_ready && b != csp_pkg::CH_SPACE) begin
            if (!s_reg.open) begin
                s_next.open = 1'b1;
                s_next.tmp = s_reg.live;
                s_next.tmp_ent = s_reg.mem[7'(s_reg.live.loc - 7'h01)];
                s_next.mem_dirty = 1'b0;
                s_next.st_req = 1'b0;
                s_next.perr = csp_pkg::ERR_NONE;
            end
            if (!s_reg.remote && s_next.perr == csp_pkg::ERR_NONE) begin
                s_next.perr = csp_pkg::NO_REMOTE_ERROR;
            end
            if (b == csp_pkg::CH_EXEC) begin
                s_next = finish_cmd(s_next);
                s_next.open = 1'b0;
                if (s_next.perr != csp_pkg::ERR_NONE) begin
                    s_next.err_bits[s_next.perr - 2'd1] = 1'b1;
                    if (s_reg.srq_mask[s_next.perr - 2'd1]) begin
                        s_next.srq = 1'b1;
                    end
                    s_next.disp_err = s_next.perr;
                    s_next.disp_cnt = 32'(ERR_CYCLES);
                end else begin
                    s_next.live = s_next.tmp;
                    if (s_next.mem_dirty) begin
                        s_next.mem[7'(s_next.tmp.loc - 7'h01)] = s_next.tmp_ent;
                    end
                    if (s_next.st_req) begin
                        s_next.test = csp_pkg::ST_ROM;
                        s_next.idx = 9'h0;
                        s_next.rom_acc = 8'h00;
                    end
                end
            end else if (b >= csp_pkg::CH_DIGIT0 && b <= csp_pkg::CH_DIGIT9) begin
                if (s_reg.cmd == csp_pkg::CMD_NONE) begin
                    if (s_next.perr == csp_pkg::ERR_NONE) begin
                        s_next.perr = csp_pkg::ILLEGAL_COMMAND_ERROR;
                    end
                end else begin
                    s_next.acc = acc_wide[csp_pkg::VAL_W-1:0];
                    s_next.ovf = s_reg.ovf || (acc_wide[19:csp_pkg::VAL_W] != '0);
                end
            end else begin
                s_next = finish_cmd(s_next);
                s_next.cmd = decode(b);
                if (s_next.cmd == csp_pkg::CMD_NONE && s_next.perr == csp_pkg::ERR_NONE) begin
                    s_next.perr = csp_pkg::ILLEGAL_COMMAND_ERROR;
                end
            end
        end
        // no bytes are taken while a test walks memory or lights the panel
        s_next.rx_ready = (s_next.test == csp_pkg::ST_IDLE);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.hready_o <= 1'b1;
            s_reg.selftest_flag <= 1'b1;
            s_reg.test <= csp_pkg::ST_RAM;
            s_reg.live.loc <= csp_pkg::LOC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end
    assign hreadyout = s_reg.hready_o;
    assign hresp = 1'b0;
    assign hrdata = s_reg.rdata;
    assign rx_ready = s_reg.rx_ready;
    assign remote = s_reg.remote;
    assign srq = s_reg.srq;
    assign leds_on = s_reg.leds_on;
    assign disp_err = s_reg.disp_err;
    assign settings = s_reg.live;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic exec_byte;
    assign exec_byte = rx.valid && s_reg.rx_ready && b == csp_pkg::CH_EXEC;
    sequence s_reject;
        exec_byte && s_next.perr != csp_pkg::ERR_NONE;
    endsequence
    property p_reject_keeps;
        s_reject |=> $stable(s_reg.live) && s_reg.test == csp_pkg::ST_IDLE;
    endproperty
    a_reject_keeps: assert property (p_reject_keeps) else $error("rejected string applied");
    property p_reject_status;
        s_reject |=> s_reg.err_bits != 3'h0 && disp_err != csp_pkg::ERR_NONE;
    endproperty
    a_reject_status: assert property (p_reject_status) else $error("error not flagged");
    // the mask bit of the very error now on show must have been set
    property p_srq_masked;
        $rose(srq) |-> disp_err != csp_pkg::ERR_NONE
            && ($past(s_reg.srq_mask) & (3'h1 << (disp_err - 2'd1))) != 3'h0;
    endproperty
    a_srq_masked: assert property (p_srq_masked) else $error("unmasked service request");
    property p_disp_hold;
        $rose(disp_err != csp_pkg::ERR_NONE) |=> (disp_err != csp_pkg::ERR_NONE) [*8];
    endproperty
    a_disp_hold: assert property (p_disp_hold) else $error("error display too short");
    property p_flag_clear;
        rd_status && s_reg.test == csp_pkg::ST_IDLE ##1 !rd_status |-> !s_reg.selftest_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag survives read");
    property p_flag_fall;
        $fell(s_reg.selftest_flag) |-> $past(rd_status);
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without read");
    sequence s_led_end;
        s_reg.test == csp_pkg::ST_LED && s_reg.led_cnt == 32'h1;
    endsequence
    property p_led_flag;
        s_led_end |=> s_reg.selftest_flag && !leds_on && s_reg.test == csp_pkg::ST_IDLE;
    endproperty
    a_led_flag: assert property (p_led_flag) else $error("flag not set after test");
    property p_led_phase;
        leds_on |-> s_reg.test == csp_pkg::ST_LED;
    endproperty
    a_led_phase: assert property (p_led_phase) else $error("indicators lit outside test");
    property p_test_stable;
        s_reg.test == csp_pkg::ST_ROM |=> $stable(s_reg.live) && $stable(s_reg.mem);
    endproperty
    a_test_stable: assert property (p_test_stable) else $error("self-test changed state");
    // an open string must carry the error; a one-byte string must already show it
    property p_no_remote;
        rx.valid && s_reg.rx_ready && b != csp_pkg::CH_SPACE && !s_reg.remote && !s_reg.open
            |=> s_reg.perr == csp_pkg::NO_REMOTE_ERROR || disp_err == csp_pkg::NO_REMOTE_ERROR;
    endproperty
    a_no_remote: assert property (p_no_remote) else $error("no-remote error missed");
    property p_remote_gtl;
        gtl |=> !remote;
    endproperty
    a_remote_gtl: assert property (p_remote_gtl) else $error("remote kept after local");
endmodule

//--- csp_link_host.sv
`timescale 1ns/10ps
module csp_link_host (
    input wire logic hclk,
    input wire logic rx_ready,
    output csp_pkg::csp_rx_s rx,
    output logic ren,
    output logic gtl
);
    initial begin
        rx = '0;
        ren = 1'b0;
        gtl = 1'b0;
    end
    // a released data line shows the inverse byte so a stale value never looks fresh
    task automatic send(input string s, input int gap);
        for (int i = 0; i < s.len(); i++) begin
            rx <= {1'b1, s[i]};
            do @(posedge hclk); while (rx_ready !== 1'b1);
            if (gap > 0 || i == s.len() - 1) begin
                rx <= {1'b0, ~s[i]};
                repeat (gap) @(posedge hclk);
            end
        end
    endtask
    task automatic set_ren(input logic v);
        ren <= v;
    endtask
    task automatic pulse_gtl();
        gtl <= 1'b1;
        @(posedge hclk);
        gtl <= 1'b0;
    endtask
endmodule

//--- command_string_parser_selftest_bench.sv
`timescale 1ns/10ps
module command_string_parser_selftest_bench;
    localparam int ERRC = 20;
    localparam int LEDC = 10;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic hready, hresp, rx_ready, ren, gtl, remote, srq, leds_on;
    logic [31:0] hrdata, rd;
    csp_pkg::csp_rx_s rx;
    csp_pkg::csp_err_e disp_err;
    csp_pkg::csp_set_s settings, exp_s;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n, f, d, p, t, l, src, lim, dw;

    always #2 hclk = ~hclk;

    csp_parser #(.ERR_CYCLES(ERRC), .LED_CYCLES(LEDC)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rx(rx), .rx_ready(rx_ready),
        .ren(ren), .gtl(gtl), .remote(remote), .srq(srq), .leds_on(leds_on),
        .disp_err(disp_err), .settings(settings));

    csp_link_host host (.hclk(hclk), .rx_ready(rx_ready), .rx(rx), .ren(ren), .gtl(gtl));

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hang anywhere ends the run as a failure
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'(hresp), 32'(0));
    endtask

    task automatic put(input string s, input int gap);
        @(posedge hclk);
        host.send(s, gap);
        @(negedge hclk);
    endtask

    function automatic csp_pkg::csp_set_s mk(input int f, d, p, t, l);
        mk = {f[0], d[1:0], p[1:0], t[2:0], l[6:0]};
    endfunction

    task automatic err_case(input string s, input int e, input logic q);
        put(s, 0);
        chk("disp_err", 32'(disp_err), 32'(e));
        chk("settings kept", 32'(settings), 32'(exp_s));
        chk("srq", 32'(srq), 32'(q));
        repeat (ERRC - 3) @(negedge hclk);
        chk("err held", 32'(disp_err), 32'(e));
        repeat (5) @(negedge hclk);
        chk("err gone", 32'(disp_err), 32'(0));
        bus(1'b0, csp_pkg::ADDR_STATUS, '0);
        chk("err bits", 32'(rd[3:1]), 32'(3'h1 << (e - 1)));
        chk("srq clear", 32'(srq), 32'(0));
    endtask

    initial begin
        n = $urandom(32'ha511b472);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        n = 0;
        while (rx_ready !== 1'b1 && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        bus(1'b0, csp_pkg::ADDR_STATUS, '0);
        chk("flag first", 32'(rd[0]), 32'(1));
        bus(1'b0, csp_pkg::ADDR_STATUS, '0);
        chk("status second", 32'(rd[7:0]), 32'(0));
        bus(1'b0, 32'h0000_0040, '0);
        chk("unmapped", rd, '0);
        bus(1'b1, csp_pkg::ADDR_CTRL, 32'h7);
        bus(1'b0, csp_pkg::ADDR_CTRL, '0);
        chk("mask", rd, 32'h7);
        exp_s = mk(0, 0, 0, 0, 1);
        err_case("F1X", 3, 1'b1);
        @(posedge hclk);
        host.set_ren(1'b1);
        repeat (3) @(negedge hclk);
        chk("remote on", 32'(remote), 32'(1));
        put("F1 D2P1T5X", 0);
        exp_s = mk(1, 2, 1, 5, 1);
        chk("multi", 32'(settings), 32'(exp_s));
        put("F0", 0);
        chk("no exec", 32'(settings), 32'(exp_s));
        put(" X", 2);
        exp_s.out_en = 1'b0;
        chk("exec", 32'(settings), 32'(exp_s));
        put("DU1X", 0);
        exp_s.disp = 2'h0;
        chk("bare", 32'(settings), 32'(exp_s));
        err_case("H1X", 1, 1'b1);
        err_case("T9X", 2, 1'b1);
        err_case("B0X", 2, 1'b1);
        err_case("F1H1T9X", 1, 1'b1);
        bus(1'b1, csp_pkg::ADDR_CTRL, 32'h2);
        err_case("H1X", 1, 1'b0);
        err_case("I65536X", 2, 1'b1);
        err_case("1F0X", 1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            f = $urandom % 2;
            d = $urandom % 4;
            p = $urandom % 3;
            t = $urandom % 6;
            l = (i == 0) ? 100 : 1 + $urandom % 100;
            src = $urandom % 65536;
            lim = $urandom % 65536;
            dw = $urandom % 65536;
            put($sformatf("F%0dD%0d P%0dT%0dB%0dI%0dV%0dW%0dX", f, d, p, t, l, src, lim, dw),
                i % 2);
            exp_s = mk(f, d, p, t, l);
            chk("rand set", 32'(settings), 32'(exp_s));
            bus(1'b1, csp_pkg::ADDR_MEM_IDX, 32'(l - 1));
            bus(1'b0, csp_pkg::ADDR_MEM_SRC_LIM, '0);
            chk("mem sl", rd, {lim[15:0], src[15:0]});
            bus(1'b0, csp_pkg::ADDR_MEM_DWELL, '0);
            chk("mem dw", rd, 32'(dw[15:0]));
        end
        put("J0X", 0);
        chk("test busy", 32'(rx_ready), 32'(0));
        n = 0;
        while (leds_on !== 1'b1 && n < 1000) begin
            @(negedge hclk);
            n++;
        end
        n = 0;
        while (leds_on === 1'b1 && n < 100) begin
            @(negedge hclk);
            n++;
        end
        chk("led time", 32'(n), 32'(LEDC));
        chk("test end", 32'(rx_ready), 32'(1));
        bus(1'b0, csp_pkg::ADDR_STATUS, '0);
        chk("flag set", 32'(rd[0]), 32'(1));
        chk("set kept", 32'(settings), 32'(exp_s));
        bus(1'b0, csp_pkg::ADDR_MEM_SRC_LIM, '0);
        chk("mem kept", rd, {lim[15:0], src[15:0]});
        @(posedge hclk);
        host.pulse_gtl();
        repeat (2) @(negedge hclk);
        chk("remote off", 32'(remote), 32'(0));
        test_done();
    end
endmodule
